// ### pll_ctrl_pkg.sv
// Constants for the primary clock controller: register map, fields, resets.
// Assumes one synchronous register port driven by the processor core or emulator.
// Function
// - Four dividers make four system clocks
// - First two dividers fixed at three, six
// - Third, fourth ratios set by own registers
// - Multiplier code 10011b gives times twenty
// - Hosts held off until configuration completes
// - Loop mode uses pre-divider then multiplier
// - Bypass routes input clock straight through
// - Only core or emulator reach registers
// - Control bit0 mode, bit3 loop reset
// - Pre-divider codes 0,1,2; reset 2h
package pll_ctrl_pkg;
   localparam logic [31:0] ADDR_RESET_TYPE = 32'h029a_00e4;
   localparam logic [31:0] ADDR_CONTROL = 32'h029a_0100;
   localparam logic [31:0] ADDR_MULT = 32'h029a_0110;
   localparam logic [31:0] ADDR_INPUT_PRE_DIVIDER = 32'h029a_0114;
   localparam logic [31:0] ADDR_COMMAND = 32'h029a_0138;
   localparam logic [31:0] ADDR_STATUS = 32'h029a_013c;
   localparam logic [31:0] ADDR_ALIGN = 32'h029a_0140;
   localparam logic [31:0] ADDR_DIVIDER_CHANGE_STATUS = 32'h029a_0144;
   localparam logic [31:0] ADDR_OUTPUT_CLOCK_STATUS = 32'h029a_0150;
   localparam logic [31:0] ADDR_DIV4 = 32'h029a_0160;
   localparam logic [31:0] ADDR_DIV5 = 32'h029a_0164;
   // Control register fields
   localparam int CTL_MODE_BIT = 0;
   localparam int CTL_PWRDN_BIT = 1;
   localparam int CTL_LRST_BIT = 3;
   localparam logic [31:0] CTL_READ_ONE = 32'h0000_0040;
   localparam logic [3:0] CTL_RESET = 4'h8;
   // Multiplier and pre-divider fields
   localparam logic [4:0] MULT_RESET = 5'h00;
   localparam int INPUT_PRE_DIVIDER_EN_BIT = 15;
   localparam logic [4:0] INPUT_PRE_DIVIDER_RATIO_RESET = 5'h02;
   localparam logic INPUT_PRE_DIVIDER_EN_RESET = 1'b1;
   localparam logic [4:0] INPUT_PRE_DIVIDER_RATIO_MAX = 5'h02;
   // Programmable divider fields and fixed divider ratios
   localparam int DIV_EN_BIT = 15;
   localparam logic [4:0] DIV4_RESET = 5'h09;
   localparam logic [4:0] DIV5_RESET = 5'h05;
   localparam logic [4:0] FIXED_A_RATIO = 5'h02;
   localparam logic [4:0] FIXED_B_RATIO = 5'h05;
   // Command, status, align bit positions
   localparam int GO_BIT = 0;
   localparam int STAT_LOCK_BIT = 1;
   localparam int STAT_RSTDONE_BIT = 2;
   localparam int ALIGN_DIV4_BIT = 3;
   localparam int ALIGN_DIV5_BIT = 4;
   localparam logic [4:0] ALIGN_RESET = 5'h18;
   // Master identities on the register port
   localparam logic [1:0] MASTER_CPU = 2'h0;
   localparam logic [1:0] MASTER_EMU = 2'h1;
   // Wait figures, in input clock periods
   localparam int LOOP_RESET_PERIODS = 128;
   localparam int LOCK_PERIODS = 2000;
   localparam int PER_W = 16;
endpackage

// ### primary_pll_clock_controller.sv
// Primary clock controller: mode select, pre-divider, multiplier, four dividers.
// Assumes the input clock arrives as a level sampled on mclk, and mclk runs
// faster than the fastest reference tick; every clock is an mclk-based pulse.
`timescale 1ns/1ps
`default_nettype none
module primary_pll_clock_controller
(
   input wire logic mclk, // System clock, 100 MHz
   input wire logic rst, // Async reset, active high
   input wire logic primaryInputClock, // Device input clock level
   input wire logic [2:0] lastResetKind, // Reset controller cause bits
   input wire logic regRead, // Register read strobe
   input wire logic regWrite, // Register write strobe
   input wire logic [1:0] regMaster, // Identity of requesting master
   input wire logic [31:0] regAddr, // Byte address
   input wire logic [31:0] regWdata, // Write data
   output logic [31:0] regRdata, // Read data, one cycle after strobe
   output logic regAck, // Answer pulse
   output logic regRefused, // Access refused pulse
   output logic referenceCoreClock, // Reference tick
   output logic busClockDiv3, // First system clock
   output logic peripheralClockDiv6, // Second system clock
   output logic externalIfClock, // Third system clock
   output logic debugTraceClock, // Fourth system clock
   output logic hostHoldoff, // Hosts must wait while high
   output logic configDone, // Pulse when configuration completes
   output logic pllLocked // Loop lock flag
);
   import pll_ctrl_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   function automatic logic [4:0] divNext(input logic [4:0] cnt, input logic [4:0] ratio);
      divNext = (cnt >= ratio) ? 5'h00 : cnt + 5'h01;
   endfunction

   function automatic logic divHigh(input logic [4:0] cnt, input logic [4:0] ratio);
      divHigh = ({cnt, 1'b0} <= {1'b0, ratio});
   endfunction

   logic [3:0] ctl_ff;
   logic [4:0] mult_ff, preRatio_ff, align_ff;
   logic [4:0] div4Pend_ff, div5Pend_ff, div4Act_ff, div5Act_ff;
   logic [4:0] cntA_ff, cntB_ff, cnt4_ff, cnt5_ff;
   logic preEn_ff, div4En_ff, div5En_ff;
   logic goPending_ff, modeEff_ff, inPrev_ff, rstDone_ff, holdPrev_ff;
   logic [PER_W-1:0] perCnt_ff, period_ff;
   logic [PER_W+2:0] acc_ff;
   logic [10:0] lockCnt_ff;
   logic [7:0] rstCnt_ff;
   logic allowed, wrEn, inEdge, phaseZero, applyGo, refTick;

   assign allowed = (regMaster == MASTER_CPU) || (regMaster == MASTER_EMU);
   assign wrEn = regWrite && allowed;
   assign inEdge = primaryInputClock && !inPrev_ff;
   // Common boundary of both fixed dividers: the slowest fixed one wraps here
   assign phaseZero = refTick && (cntB_ff == FIXED_B_RATIO);
   assign applyGo = goPending_ff && phaseZero;
   ////////////////////////////////////////////////////////////////////////
   // Register writes; reserved bits are not stored
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         ctl_ff <= CTL_RESET;
         mult_ff <= MULT_RESET;
         preRatio_ff <= INPUT_PRE_DIVIDER_RATIO_RESET;
         preEn_ff <= INPUT_PRE_DIVIDER_EN_RESET;
         div4Pend_ff <= DIV4_RESET;
         div5Pend_ff <= DIV5_RESET;
         div4En_ff <= 1'b1;
         div5En_ff <= 1'b1;
         align_ff <= ALIGN_RESET;
      end
      else if (wrEn)
      begin
         case (regAddr)
            ADDR_CONTROL:
            begin
               ctl_ff[CTL_MODE_BIT] <= regWdata[CTL_MODE_BIT];
               ctl_ff[CTL_PWRDN_BIT] <= regWdata[CTL_PWRDN_BIT];
               ctl_ff[CTL_LRST_BIT] <= regWdata[CTL_LRST_BIT];
            end
            ADDR_MULT: mult_ff <= regWdata[4:0];
            ADDR_INPUT_PRE_DIVIDER:
            begin
               // Reserved ratio codes are dropped rather than stored; the previous ratio is kept
               if (regWdata[4:0] <= INPUT_PRE_DIVIDER_RATIO_MAX)
               begin
                  preRatio_ff <= regWdata[4:0];
               end
               preEn_ff <= regWdata[INPUT_PRE_DIVIDER_EN_BIT];
            end
            ADDR_DIV4:
            begin
               div4Pend_ff <= regWdata[4:0];
               div4En_ff <= regWdata[DIV_EN_BIT];
            end
            ADDR_DIV5:
            begin
               div5Pend_ff <= regWdata[4:0];
               div5En_ff <= regWdata[DIV_EN_BIT];
            end
            ADDR_ALIGN:
            begin
               align_ff[ALIGN_DIV4_BIT] <= regWdata[ALIGN_DIV4_BIT];
               align_ff[ALIGN_DIV5_BIT] <= regWdata[ALIGN_DIV5_BIT];
            end
            default: ;
         endcase
      end
   end
   ////////////////////////////////////////////////////////////////////////
   // Go command; a new request in the completing cycle stays pending
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         goPending_ff <= 1'b0;
         div4Act_ff <= DIV4_RESET;
         div5Act_ff <= DIV5_RESET;
      end
      else
      begin
         if (wrEn && regAddr == ADDR_COMMAND && regWdata[GO_BIT])
         begin
            goPending_ff <= 1'b1;
         end
         else if (applyGo)
         begin
            goPending_ff <= 1'b0;
         end
         if (applyGo)
         begin
            div4Act_ff <= div4Pend_ff;
            div5Act_ff <= div5Pend_ff;
         end
      end
   end
   ////////////////////////////////////////////////////////////////////////
   // Input clock period, measured in mclk cycles
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         inPrev_ff <= 1'b0;
         perCnt_ff <= '0;
         period_ff <= '0;
      end
      else
      begin
         inPrev_ff <= primaryInputClock;
         if (inEdge)
         begin
            period_ff <= perCnt_ff + 1'b1;
            perCnt_ff <= '0;
         end
         else if (perCnt_ff != '1)
         begin
            perCnt_ff <= perCnt_ff + 1'b1;
         end
      end
   end
   ////////////////////////////////////////////////////////////////////////
   // Loop model: ticks at input rate times (code+1) over pre-divide.
   // Limitation: ticks cannot exceed mclk rate, so figures scale down.
   logic [PER_W+2:0] thresh;
   logic [PER_W+2:0] accSum;
   logic loopRun;
   assign thresh = (PER_W+3)'(period_ff) * (PER_W+3)'({1'b0, preRatio_ff} + 6'd1);
   assign accSum = acc_ff + (PER_W+3)'({1'b0, mult_ff} + 6'd1);
   assign loopRun = preEn_ff && pllLocked && !ctl_ff[CTL_PWRDN_BIT] && (period_ff != '0);

   logic loopTick;
   assign loopTick = loopRun && (accSum >= thresh);
   assign refTick = modeEff_ff ? loopTick : inEdge;

   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         acc_ff <= '0;
      end
      else if (!loopRun)
      begin
         acc_ff <= '0;
      end
      else
      begin
         acc_ff <= loopTick ? accSum - thresh : accSum;
      end
   end
   ////////////////////////////////////////////////////////////////////////
   // Mode changes at the common divider boundary, or at once while the loop is not running
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         modeEff_ff <= 1'b0;
      end
      else if (modeEff_ff != ctl_ff[CTL_MODE_BIT])
      begin
         // Loop source stopped: nothing in flight, switch at once
         if (phaseZero || !loopRun)
         begin
            modeEff_ff <= ctl_ff[CTL_MODE_BIT];
         end
      end
   end
   ////////////////////////////////////////////////////////////////////////
   // Four dividers clocked by the reference tick
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         cntA_ff <= '0;
         cntB_ff <= '0;
         cnt4_ff <= '0;
         cnt5_ff <= '0;
      end
      else if (refTick)
      begin
         cntA_ff <= divNext(cntA_ff, FIXED_A_RATIO);
         cntB_ff <= divNext(cntB_ff, FIXED_B_RATIO);
         cnt4_ff <= applyGo ? 5'h00 : divNext(cnt4_ff, div4Act_ff);
         cnt5_ff <= applyGo ? 5'h00 : divNext(cnt5_ff, div5Act_ff);
      end
   end

   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         referenceCoreClock <= 1'b0;
         busClockDiv3 <= 1'b0;
         peripheralClockDiv6 <= 1'b0;
         externalIfClock <= 1'b0;
         debugTraceClock <= 1'b0;
      end
      else
      begin
         referenceCoreClock <= refTick;
         busClockDiv3 <= divHigh(cntA_ff, FIXED_A_RATIO);
         peripheralClockDiv6 <= divHigh(cntB_ff, FIXED_B_RATIO);
         externalIfClock <= div4En_ff && divHigh(cnt4_ff, div4Act_ff);
         debugTraceClock <= div5En_ff && divHigh(cnt5_ff, div5Act_ff);
      end
   end
   ////////////////////////////////////////////////////////////////////////
   // Loop reset and lock timing, counted in input periods
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         rstCnt_ff <= '0;
         rstDone_ff <= 1'b0;
         lockCnt_ff <= '0;
         pllLocked <= 1'b0;
      end
      else if (ctl_ff[CTL_LRST_BIT] || ctl_ff[CTL_PWRDN_BIT])
      begin
         lockCnt_ff <= '0;
         pllLocked <= 1'b0;
         if (inEdge && !rstDone_ff)
         begin
            rstCnt_ff <= rstCnt_ff + 1'b1;
            rstDone_ff <= (rstCnt_ff == 8'(LOOP_RESET_PERIODS - 1));
         end
      end
      else
      begin
         rstCnt_ff <= '0;
         rstDone_ff <= 1'b0;
         if (inEdge && !pllLocked)
         begin
            lockCnt_ff <= lockCnt_ff + 1'b1;
            pllLocked <= (lockCnt_ff == 11'(LOCK_PERIODS - 1));
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Host hold-off while a go command or a mode change is pending
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         hostHoldoff <= 1'b1;
         holdPrev_ff <= 1'b1;
         configDone <= 1'b0;
      end
      else
      begin
         hostHoldoff <= goPending_ff || (modeEff_ff != ctl_ff[CTL_MODE_BIT]);
         holdPrev_ff <= hostHoldoff;
         configDone <= holdPrev_ff && !hostHoldoff;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Read path; unmapped addresses read zero, other masters refused
   logic [31:0] rdVal;
   always_comb
   begin
      rdVal = 32'h0000_0000;
      case (regAddr)
         ADDR_RESET_TYPE: rdVal = {29'h0000_0000, lastResetKind};
         ADDR_CONTROL: rdVal = CTL_READ_ONE | {28'h000_0000, ctl_ff[3], 1'b0, ctl_ff[1:0]};
         ADDR_MULT: rdVal = {27'h000_0000, mult_ff};
         ADDR_INPUT_PRE_DIVIDER: rdVal = {16'h0000, preEn_ff, 10'h000, preRatio_ff};
         ADDR_STATUS: rdVal = {29'h0000_0000, rstDone_ff, pllLocked, goPending_ff};
         ADDR_ALIGN: rdVal = {27'h000_0000, align_ff[4:3], 3'h0};
         ADDR_DIVIDER_CHANGE_STATUS: rdVal = {27'h000_0000, div5Pend_ff != div5Act_ff,
                                div4Pend_ff != div4Act_ff, 3'h0};
         ADDR_OUTPUT_CLOCK_STATUS: rdVal = {27'h000_0000, debugTraceClock, externalIfClock,
                               peripheralClockDiv6, busClockDiv3, referenceCoreClock};
         ADDR_DIV4: rdVal = {16'h0000, div4En_ff, 10'h000, div4Pend_ff};
         ADDR_DIV5: rdVal = {16'h0000, div5En_ff, 10'h000, div5Pend_ff};
         default: rdVal = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         regRdata <= 32'h0000_0000;
         regAck <= 1'b0;
         regRefused <= 1'b0;
      end
      else
      begin
         regAck <= (regRead || regWrite) && allowed;
         regRefused <= (regRead || regWrite) && !allowed;
         regRdata <= (regRead && allowed) ? rdVal : 32'h0000_0000;
      end
   end

endmodule // primary_pll_clock_controller
`default_nettype wire

// ### primary_pll_clock_controller_properties.sv
// Checker for the primary clock controller: register answers and clock outputs.
// Assumes it is bound onto primary_pll_clock_controller and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module pll_ctrl_checker
   import pll_ctrl_pkg::*;
(
   input wire logic mclk, // Clock
   input wire logic rst, // Reset
   input wire logic regRead, // Read strobe
   input wire logic regWrite, // Write strobe
   input wire logic [1:0] regMaster, // Master id
   input wire logic [31:0] regAddr, // Address
   input wire logic [31:0] regRdata, // Read data
   input wire logic regAck, // Accepted
   input wire logic regRefused, // Refused
   input wire logic referenceCoreClock, // Tick
   input wire logic busClockDiv3, // Div 3
   input wire logic peripheralClockDiv6, // Div 6
   input wire logic hostHoldoff, // Hold-off
   input wire logic configDone // Done pulse
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff rst;
   logic anyReq;
   assign anyReq = regRead | regWrite;
   ////////////////////////////////////////////////////////////////////////////////
   sequence s_holdFall;
      hostHoldoff ##1 !hostHoldoff;
   endsequence
   property p_refuse;
      anyReq && regMaster[1] |=> regRefused && !regAck && regRdata == 32'h0000_0000;
   endproperty
   property p_accept;
      anyReq && !regMaster[1] |=> regAck && !regRefused;
   endproperty
   property p_quiet;
      !anyReq |=> !regAck && !regRefused && regRdata == 32'h0000_0000;
   endproperty
   property p_ctlRead;
      regRead && !regMaster[1] && regAddr == ADDR_CONTROL |=>
         regRdata[31:4] == 28'h000_0004 && !regRdata[2];
   endproperty
   property p_preRead;
      regRead && !regMaster[1] && regAddr == ADDR_INPUT_PRE_DIVIDER |=>
         regRdata[31:16] == 16'h0000 && regRdata[14:5] == 10'h000 && regRdata[4:0] <= 5'h02;
   endproperty
   // Both outputs settle once on the first edge out of reset, with no tick
   property p_fixedTick;
      $changed(busClockDiv3) || $changed(peripheralClockDiv6) |->
         $past(referenceCoreClock) || $past(rst, 2);
   endproperty
   property p_phase;
      $changed(peripheralClockDiv6) |-> $rose(busClockDiv3);
   endproperty
   property p_noRunt;
      $rose(busClockDiv3) |=> busClockDiv3;
   endproperty
   property p_doneAfter;
      s_holdFall |=> configDone;
   endproperty
   property p_doneOnly;
      configDone |-> $past(hostHoldoff, 2) && !$past(hostHoldoff);
   endproperty
   ////////////////////////////////////////////////////////////////////////////////
   a_refuse: assert property (p_refuse) else $error("refused access answered");
   a_accept: assert property (p_accept) else $error("access not acknowledged");
   a_quiet: assert property (p_quiet) else $error("answer without request");
   a_ctlRead: assert property (p_ctlRead) else $error("control fixed bits wrong");
   a_preRead: assert property (p_preRead) else $error("pre-divider read wrong");
   a_fixedTick: assert property (p_fixedTick) else $error("divider moved off tick");
   a_phase: assert property (p_phase) else $error("div6 out of step with div3");
   a_noRunt: assert property (p_noRunt) else $error("runt pulse on div3");
   a_doneAfter: assert property (p_doneAfter) else $error("done missing");
   a_doneOnly: assert property (p_doneOnly) else $error("stray done pulse");
endmodule // pll_ctrl_checker

bind primary_pll_clock_controller pll_ctrl_checker u_chk (.mclk(mclk), .rst(rst),
   .regRead(regRead), .regWrite(regWrite), .regMaster(regMaster), .regAddr(regAddr),
   .regRdata(regRdata), .regAck(regAck), .regRefused(regRefused),
   .referenceCoreClock(referenceCoreClock), .busClockDiv3(busClockDiv3),
   .peripheralClockDiv6(peripheralClockDiv6), .hostHoldoff(hostHoldoff),
   .configDone(configDone));
`default_nettype wire

// ### primary_pll_clock_controller_tb_top.sv
// Self-checking bench for the primary clock controller.
// Assumes the package and checker are compiled first; input clock is mclk/4.
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin miscompares++; \
   $display("mismatch at %0t: got %0h want %0h", $time, got, exp); end end
module primary_pll_clock_controller_tb_top;
   import pll_ctrl_pkg::*;
   logic mclk = 1'b0;
   logic rst = 1'b1;
   logic primaryInputClock = 1'b0;
   logic [1:0] icCnt = 2'h0;
   logic regRead = 1'b0;
   logic regWrite = 1'b0;
   logic [1:0] regMaster = 2'h0;
   logic [31:0] regAddr = 32'h0000_0000;
   logic [31:0] regWdata = 32'h0000_0000;
   logic [31:0] regRdata;
   logic regAck, regRefused, referenceCoreClock, busClockDiv3, peripheralClockDiv6;
   logic externalIfClock, debugTraceClock, hostHoldoff, configDone, pllLocked;
   int miscompares = 0;
   int cmp_count = 0;
   int tally[5];

   always #5 mclk = ~mclk;
   always @(negedge mclk)
   begin
      icCnt <= icCnt + 2'h1;
      primaryInputClock <= icCnt[1];
   end

   primary_pll_clock_controller DUT (.mclk(mclk), .rst(rst),
      .primaryInputClock(primaryInputClock), .lastResetKind(3'h5), .regRead(regRead),
      .regWrite(regWrite), .regMaster(regMaster), .regAddr(regAddr), .regWdata(regWdata),
      .regRdata(regRdata), .regAck(regAck), .regRefused(regRefused),
      .referenceCoreClock(referenceCoreClock), .busClockDiv3(busClockDiv3),
      .peripheralClockDiv6(peripheralClockDiv6), .externalIfClock(externalIfClock),
      .debugTraceClock(debugTraceClock), .hostHoldoff(hostHoldoff),
      .configDone(configDone), .pllLocked(pllLocked));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] m);
      @(negedge mclk);
      regWrite = 1'b1;
      regAddr = a;
      regWdata = d;
      regMaster = m;
      @(negedge mclk);
      `CHK({regAck, regRefused}, m[1] ? 2'b01 : 2'b10)
      regWrite = 1'b0;
   endtask

   task automatic rdc(input logic [31:0] a, input logic [1:0] m, input logic [31:0] e);
      @(negedge mclk);
      regRead = 1'b1;
      regAddr = a;
      regMaster = m;
      @(negedge mclk);
      `CHK({regAck, regRefused}, m[1] ? 2'b01 : 2'b10)
      `CHK(regRdata, e)
      regRead = 1'b0;
   endtask

   // Hold-off must be seen before the done pulse
   task automatic holdWait();
      logic seen;
      seen = 1'b0;
      for (int i = 0; i < 300 && configDone !== 1'b1; i++)
      begin
         @(negedge mclk);
         seen |= hostHoldoff;
      end
      `CHK({seen, configDone}, 2'b11)
   endtask

   // Window starts on a tick so whole periods are counted
   task automatic cnt(input int n);
      logic [3:0] pv, cur;
      tally = '{default: 0};
      for (int i = 0; i < 50 && referenceCoreClock !== 1'b1; i++)
         @(negedge mclk);
      pv = {debugTraceClock, externalIfClock, peripheralClockDiv6, busClockDiv3};
      repeat (n)
      begin
         @(negedge mclk);
         cur = {debugTraceClock, externalIfClock, peripheralClockDiv6, busClockDiv3};
         tally[0] += int'(referenceCoreClock);
         for (int j = 0; j < 4; j++)
            tally[j + 1] += int'(cur[j] & ~pv[j]);
         pv = cur;
      end
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_regs();
      rdc(ADDR_CONTROL, 2'h0, 32'h0000_0048);
      rdc(ADDR_INPUT_PRE_DIVIDER, 2'h1, 32'h0000_8002);
      rdc(ADDR_DIV4, 2'h0, 32'h0000_8009);
      rdc(ADDR_DIV5, 2'h0, 32'h0000_8005);
      rdc(ADDR_RESET_TYPE, 2'h0, 32'h0000_0005);
      wr(ADDR_MULT, 32'h0000_0013, 2'h2);
      rdc(ADDR_MULT, 2'h3, 32'h0000_0000);
      rdc(ADDR_MULT, 2'h0, 32'h0000_0000);
      wr(ADDR_MULT, 32'h0000_0013, 2'h1);
      rdc(ADDR_MULT, 2'h0, 32'h0000_0013);
      rdc(ADDR_ALIGN, 2'h0, 32'h0000_0018);
      wr(ADDR_ALIGN, 32'h0000_0000, 2'h0);
      rdc(ADDR_ALIGN, 2'h0, 32'h0000_0000);
      rdc(32'h029a_0104, 2'h0, 32'h0000_0000);
      wr(ADDR_CONTROL, 32'h0000_0008, 2'h0);
      rdc(ADDR_CONTROL, 2'h0, 32'h0000_0048);
      for (int c = 0; c < 4; c++)
      begin
         wr(ADDR_INPUT_PRE_DIVIDER, 32'h0000_8000 | c, 2'h0);
         rdc(ADDR_INPUT_PRE_DIVIDER, 2'h0, 32'h0000_8000 | (c == 3 ? 2 : c));
      end
      $display("t_regs done");
   endtask

   task automatic t_bypass();
      cnt(120);
      `CHK(tally[0], 30)
      `CHK(tally[1], 10)
      `CHK(tally[2], 5)
      `CHK(tally[3], 3)
      `CHK(tally[4], 5)
      wr(ADDR_DIV4, 32'h0000_8004, 2'h0);
      wr(ADDR_DIV5, 32'h0000_8001, 2'h0);
      rdc(ADDR_DIVIDER_CHANGE_STATUS, 2'h0, 32'h0000_0018);
      wr(ADDR_COMMAND, 32'h0000_0001, 2'h0);
      holdWait();
      rdc(ADDR_DIVIDER_CHANGE_STATUS, 2'h0, 32'h0000_0000);
      cnt(120);
      `CHK(tally[1], 10)
      `CHK(tally[2], 5)
      `CHK(tally[3], 6)
      `CHK(tally[4], 15)
      $display("t_bypass done");
   endtask

   task automatic t_loop();
      repeat (15000) @(negedge mclk);
      rdc(ADDR_STATUS, 2'h0, 32'h0000_0004);
      wr(ADDR_CONTROL, 32'h0000_0000, 2'h0);
      for (int i = 0; i < 9000 && pllLocked !== 1'b1; i++)
         @(negedge mclk);
      `CHK(pllLocked, 1'b1)
      wr(ADDR_MULT, 32'h0000_0001, 2'h0);
      wr(ADDR_INPUT_PRE_DIVIDER, 32'h0000_8000, 2'h0);
      wr(ADDR_CONTROL, 32'h0000_0001, 2'h0);
      holdWait();
      cnt(120);
      `CHK(tally[0] inside {[59:61]}, 1'b1)
      wr(ADDR_CONTROL, 32'h0000_0000, 2'h0);
      holdWait();
      cnt(120);
      `CHK(tally[0], 30)
      // Power-down drops lock while bypass keeps running
      wr(ADDR_CONTROL, 32'h0000_0042, 2'h0);
      rdc(ADDR_CONTROL, 2'h0, 32'h0000_0042);
      `CHK(pllLocked, 1'b0)
      $display("t_loop done");
   endtask

   task automatic test_done();
      $display("compares %0d, mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      repeat (40000) @(posedge mclk);
      miscompares++;
      test_done();
   end

   initial
   begin
      repeat (4) @(posedge mclk);
      @(negedge mclk);
      rst = 1'b0;
      t_regs();
      t_bypass();
      t_loop();
      test_done();
   end
endmodule // primary_pll_clock_controller_tb_top
`default_nettype wire
